// File: hw/cfg_serial_port.v
// Three-wire configuration serial port, device side
// Operation
// - Three pins: clock, data, active-low select
// - Frame starts at first rise after select falls
// - Length bits 11 with select held low means continuous streaming
// - Select high between bytes stalls, state kept
// - Select idle high releases data pin
// - Sixteen-bit instruction, length bits set bytes
// - Data moves in eight-bit register bytes
// - First bit chooses read or write
// - Read turns data pin around at data
// - Bit order MSB first, LSB selectable
// - Clock and select only sampled, never driven
// - Registers choose power-down or standby
// - Shadowed writes apply on transfer write
// - Channel writes reach all selected channels
// - Both selected on read returns channel A
`timescale 1ns/1ps
`include "cfg_port_map.vh"
module cfg_serial_port #(
    parameter MEM_AW = 8
) (
    input wire clk_sys_i, // System clock 100 MHz
    input wire rst_i, // Synchronous reset, active high
    input wire sclk_i, // Serial clock pin
    input wire cs_n_i, // Chip select pin, active low
    input wire sdio_i, // Data pin input
    output reg sdio_o, // Data pin output
    output reg sdio_oe_o, // Data pin output enable
    output reg [1:0] power_mode_o, // Applied power mode
    output reg duty_cycle_stabilizer_o, // Applied stabilizer enable
    output reg [7:0] chan_a_cfg_o, // Applied channel A memory byte at the transfer address
    output reg [7:0] chan_b_cfg_o, // Applied channel B memory byte at the transfer address
    output reg port_active_o // Frame in progress
);
    // ------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------
    reg [1:0] sclk_sync_reg;
    reg [1:0] cs_sync_reg;
    reg [1:0] sdio_sync_reg;
    reg sclk_d_reg;
    wire sclk_rise;
    wire sclk_fall;
    wire cs_low;
    always @(posedge clk_sys_i)
    begin
        sclk_sync_reg <= {sclk_sync_reg[0], sclk_i};
        cs_sync_reg <= {cs_sync_reg[0], cs_n_i};
        sdio_sync_reg <= {sdio_sync_reg[0], sdio_i};
        sclk_d_reg <= sclk_sync_reg[1];
    end
    assign sclk_rise = sclk_sync_reg[1] & ~sclk_d_reg;
    assign sclk_fall = ~sclk_sync_reg[1] & sclk_d_reg;
    assign cs_low = ~cs_sync_reg[1];

    // ------------------------------------------------------------
    // Frame state
    // ------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_INSTR = 2'h1;
    localparam ST_DATA = 2'h2;
    localparam ST_DONE = 2'h3;

    reg [1:0] state_reg;
    reg [3:0] bit_cnt_reg;
    reg [15:0] shift_reg;
    reg rw_reg;
    reg [1:0] len_reg;
    reg [1:0] bytes_reg;
    reg [`ADDR_W-1:0] addr_reg;
    reg [7:0] tx_reg;
    reg lsb_first_reg;
    reg [7:0] chan_index_reg;
    reg [7:0] power_mode_sh_reg;
    reg [7:0] clock_cfg_sh_reg;
    reg wr_pend_reg;
    reg rd_pend_reg;
    reg load_tx_reg;

    wire [15:0] shift_next;
    wire [3:0] last_bit;
    wire [7:0] rx_byte;
    wire [`ADDR_W-1:0] addr_next;

    // Shift direction follows the configured bit order
    assign shift_next = lsb_first_reg ?
        {sdio_sync_reg[1], shift_reg[15:1]} :
        {shift_reg[14:0], sdio_sync_reg[1]};
    assign last_bit = (state_reg == ST_INSTR) ? 4'hF : 4'h7;
    // Received byte sits at the end the bits were shifted in at
    assign rx_byte = lsb_first_reg ? shift_reg[15:8] : shift_reg[7:0];
    // Address walks down in MSB mode, up in LSB mode
    assign addr_next = lsb_first_reg ? addr_reg + 13'h0001 :
        addr_reg - 13'h0001;

    // Reverse bit order of a byte
    function [7:0] rev8;
        input [7:0] b;
        integer k;
        begin
            for (k = 0; k < 8; k = k + 1)
                rev8[k] = b[7-k];
        end
    endfunction

    // Instruction decode after sixteen bits
    function [15:0] instr_word;
        input [15:0] s;
        input lsb;
        begin
            instr_word = lsb ? {s[0], s[2:1], s[15:3]} : s;
        end
    endfunction

    wire [15:0] instr = instr_word(shift_next, lsb_first_reg);

    // ------------------------------------------------------------
    // Channel memories
    // ------------------------------------------------------------
    wire [7:0] rd_a;
    wire [7:0] rd_b;
    wire local_addr = (addr_reg >= 13'h0010) &&
        (addr_reg < `ADDR_TRANSFER);
    wire we_a = wr_pend_reg & local_addr & chan_index_reg[0];
    wire we_b = wr_pend_reg & local_addr & chan_index_reg[1];

    cfg_reg_mem #(.AW(MEM_AW), .DW(8)) mem_a (
        .clk_sys_i(clk_sys_i),
        .we_i(we_a),
        .waddr_i(addr_reg[MEM_AW-1:0]),
        .wdata_i(rx_byte),
        .raddr_i(addr_reg[MEM_AW-1:0]),
        .rdata_o(rd_a)
    );
    cfg_reg_mem #(.AW(MEM_AW), .DW(8)) mem_b (
        .clk_sys_i(clk_sys_i),
        .we_i(we_b),
        .waddr_i(addr_reg[MEM_AW-1:0]),
        .wdata_i(rx_byte),
        .raddr_i(addr_reg[MEM_AW-1:0]),
        .rdata_o(rd_b)
    );

    // Global readback; channel A wins when both are selected
    reg [7:0] rd_mux;
    always @*
    begin
        rd_mux = 8'h00;
        if (addr_reg == `ADDR_PORT_CFG)
            rd_mux = {1'b0, lsb_first_reg, 6'h00};
        else if (addr_reg == `ADDR_CHAN_INDEX)
            rd_mux = chan_index_reg;
        else if (addr_reg == `ADDR_POWER_MODE)
            rd_mux = power_mode_sh_reg;
        else if (addr_reg == `ADDR_CLOCK_CFG)
            rd_mux = clock_cfg_sh_reg;
        else if (local_addr)
            rd_mux = chan_index_reg[0] ? rd_a : rd_b;
    end

    // ------------------------------------------------------------
    // Serial engine
    // ------------------------------------------------------------
    always @(posedge clk_sys_i)
    begin
        wr_pend_reg <= 1'b0;
        rd_pend_reg <= 1'b0;
        load_tx_reg <= rd_pend_reg;
        if (rst_i)
        begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 16'h0000;
            rw_reg <= 1'b0;
            len_reg <= 2'h0;
            bytes_reg <= 2'h0;
            addr_reg <= {`ADDR_W{1'b0}};
            tx_reg <= 8'h00;
            lsb_first_reg <= 1'b0;
            chan_index_reg <= `CHAN_INDEX_RESET;
            power_mode_sh_reg <= `POWER_MODE_RESET;
            clock_cfg_sh_reg <= `CLOCK_CFG_RESET;
            power_mode_o <= 2'h0;
            duty_cycle_stabilizer_o <= 1'b1;
            chan_a_cfg_o <= 8'h00;
            chan_b_cfg_o <= 8'h00;
            sdio_o <= 1'b0;
            sdio_oe_o <= 1'b0;
            port_active_o <= 1'b0;
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            load_tx_reg <= 1'b0;
        end
        else
        begin
            if (load_tx_reg)
                tx_reg <= lsb_first_reg ? rev8(rd_mux) : rd_mux;
            if (state_reg == ST_IDLE)
            begin
                sdio_oe_o <= 1'b0;
                port_active_o <= 1'b0;
                if (cs_low)
                begin
                    state_reg <= ST_INSTR;
                    bit_cnt_reg <= 4'h0;
                    port_active_o <= 1'b1;
                end
            end
            else if (!cs_low)
            begin
                // Stall at byte boundary keeps state, else abandon
                sdio_oe_o <= 1'b0;
                if (bit_cnt_reg != 4'h0 || state_reg == ST_DONE)
                    state_reg <= ST_IDLE;
            end
            else if (sclk_rise && state_reg != ST_DONE)
            begin
                shift_reg <= shift_next;
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                if (bit_cnt_reg == last_bit)
                begin
                    bit_cnt_reg <= 4'h0;
                    if (state_reg == ST_INSTR)
                    begin
                        rw_reg <= instr[15];
                        len_reg <= instr[14:13];
                        bytes_reg <= instr[14:13];
                        addr_reg <= instr[12:0];
                        state_reg <= ST_DATA;
                        rd_pend_reg <= instr[15];
                    end
                    else
                    begin
                        if (!rw_reg)
                            wr_pend_reg <= 1'b1;
                        else
                            rd_pend_reg <= 1'b1;
                        if (len_reg != `LEN_STREAM)
                        begin
                            if (bytes_reg == 2'h0)
                                state_reg <= ST_DONE;
                            bytes_reg <= bytes_reg - 2'h1;
                        end
                    end
                end
            end
            else if (sclk_fall && state_reg == ST_DATA && rw_reg)
            begin
                // Drive next read bit on falling edge
                sdio_oe_o <= 1'b1;
                sdio_o <= tx_reg[7];
                tx_reg <= {tx_reg[6:0], 1'b0};
            end
            else if (state_reg == ST_DONE && sclk_fall)
                sdio_oe_o <= 1'b0;

            // Register write side effects
            if (wr_pend_reg)
            begin
                addr_reg <= addr_next;
                if (addr_reg == `ADDR_PORT_CFG)
                    lsb_first_reg <= rx_byte[`PORT_CFG_LSB_BIT];
                else if (addr_reg == `ADDR_CHAN_INDEX)
                    chan_index_reg <= {6'h00, rx_byte[1:0]};
                else if (addr_reg == `ADDR_POWER_MODE)
                begin
                    // Power mode is not shadowed, applies at once
                    power_mode_sh_reg <= rx_byte;
                    power_mode_o <= rx_byte[1:0];
                end
                else if (addr_reg == `ADDR_CLOCK_CFG)
                    clock_cfg_sh_reg <= rx_byte;
                else if (addr_reg == `ADDR_TRANSFER &&
                    rx_byte == `TRANSFER_GO)
                begin
                    // Transfer bit self-clears; all shadows apply
                    power_mode_o <= power_mode_sh_reg[1:0];
                    duty_cycle_stabilizer_o <= clock_cfg_sh_reg[0];
                    chan_a_cfg_o <= rd_a;
                    chan_b_cfg_o <= rd_b;
                end
            end
            if (load_tx_reg && rw_reg)
                addr_reg <= addr_next;
        end
    end
endmodule // cfg_serial_port

// File: hw/cfg_port_map.vh
// Constants for the converter configuration serial port
`ifndef CFG_PORT_MAP_VH
`define CFG_PORT_MAP_VH
`define ADDR_W 13
`define ADDR_PORT_CFG 13'h0000
`define ADDR_CHAN_INDEX 13'h0005
`define ADDR_POWER_MODE 13'h0008
`define ADDR_CLOCK_CFG 13'h0009
`define ADDR_TRANSFER 13'h00FF
`define TRANSFER_GO 8'h01
`define PORT_CFG_LSB_BIT 6
`define PORT_CFG_RESET 8'h00
`define CHAN_INDEX_RESET 8'h03
`define POWER_MODE_RESET 8'h00
`define CLOCK_CFG_RESET 8'h01
`define INSTR_BITS 16
`define WORD_BITS 8
`define LEN_STREAM 2'h3
`endif

// File: hw/cfg_reg_mem.v
// Small register memory with registered read data, one per channel
`timescale 1ns/1ps
module cfg_reg_mem #(
    parameter AW = 8,
    parameter DW = 8
) (
    input wire clk_sys_i, // System clock
    input wire we_i, // Write enable
    input wire [AW-1:0] waddr_i, // Write address
    input wire [DW-1:0] wdata_i, // Write data
    input wire [AW-1:0] raddr_i, // Read address
    output reg [DW-1:0] rdata_o // Registered read data
);
    reg [DW-1:0] mem_reg [0:(1<<AW)-1];
    integer i;
    initial
    begin
        for (i = 0; i < (1<<AW); i = i + 1)
            mem_reg[i] = {DW{1'b0}};
    end
    always @(posedge clk_sys_i)
    begin
        if (we_i)
            mem_reg[waddr_i] <= wdata_i;
        rdata_o <= mem_reg[raddr_i];
    end
endmodule // cfg_reg_mem

// File: tb/cfg_port_checker.sv
// Assertions on the configuration serial port outputs
`timescale 1ns/1ps
module cfg_port_checker #(
    parameter MEM_AW = 8
) (
    input wire clk_sys_i, // Clock
    input wire rst_i, // Reset
    input wire sclk_i, // Serial clock
    input wire cs_n_i, // Select
    input wire sdio_i, // Data in
    input wire sdio_o, // Data out
    input wire sdio_oe_o, // Data enable
    input wire [1:0] power_mode_o, // Power mode
    input wire duty_cycle_stabilizer_o, // Stabilizer
    input wire [7:0] chan_a_cfg_o, // Channel A
    input wire [7:0] chan_b_cfg_o, // Channel B
    input wire port_active_o // Frame flag
);
    reg sclk_reg = 1'b0;
    reg [4:0] rise_reg = 5'h00;
    reg [5:0] idle_reg = 6'h00;
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    // Serial rises since select last idled
    always @(posedge clk_sys_i)
    begin
        sclk_reg <= sclk_i;
        idle_reg <= cs_n_i ? idle_reg + {5'h00, ~&idle_reg} : 6'h00;
        if (rst_i || idle_reg[5])
            rise_reg <= 5'h00;
        else if (sclk_i && !sclk_reg && !rise_reg[4])
            rise_reg <= rise_reg + 5'h01;
    end
    sequence cs_idle_s;
        cs_n_i [*6];
    endsequence
    a_pin_released: assert property (cs_idle_s |-> !sdio_oe_o)
        else $error("data pin driven while idle");
    a_oe_after_instr: assert property (!rise_reg[4] |-> !sdio_oe_o)
        else $error("data pin driven in instruction");
    a_oe_on_low: assert property ($rose(sdio_oe_o) |-> !sclk_i)
        else $error("turnaround not on low clock");
    a_data_on_fall: assert property (sdio_oe_o && $past(sdio_oe_o)
        && $changed(sdio_o) |-> !sclk_i) else $error("data moved on high");
    a_reset_vals: assert property ($fell(rst_i) |-> duty_cycle_stabilizer_o
        && power_mode_o == 2'h0 && chan_a_cfg_o == 8'h00 && !port_active_o)
        else $error("reset values wrong");
    a_power_on_byte: assert property ($changed(power_mode_o) |-> sclk_i)
        else $error("power mode moved mid byte");
    a_stab_on_byte: assert property ($changed(duty_cycle_stabilizer_o)
        |-> sclk_i) else $error("stabilizer moved mid byte");
    a_chan_on_byte: assert property ($changed(chan_a_cfg_o)
        || $changed(chan_b_cfg_o) |-> sclk_i) else $error("chan moved");
    a_active_idle: assert property (idle_reg[5] |-> !port_active_o)
        else $error("frame flag while idle");
endmodule // cfg_port_checker
bind cfg_serial_port cfg_port_checker #(.MEM_AW(MEM_AW)) i_chk (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .sclk_i(sclk_i),
    .cs_n_i(cs_n_i), .sdio_i(sdio_i), .sdio_o(sdio_o),
    .sdio_oe_o(sdio_oe_o), .power_mode_o(power_mode_o),
    .duty_cycle_stabilizer_o(duty_cycle_stabilizer_o),
    .chan_a_cfg_o(chan_a_cfg_o), .chan_b_cfg_o(chan_b_cfg_o),
    .port_active_o(port_active_o)
);

// File: tb/spi_master_model.sv
// Serial master model that frames instructions and bytes
`timescale 1ns/1ps
module spi_master_model (
    input wire clk_sys_i, // Clock
    input wire sdio_i, // Resolved data wire
    output reg sclk_o = 1'b0, // Serial clock, still when idle
    output reg cs_n_o = 1'b1, // Select
    output reg sdio_o = 1'b0, // Master data
    output reg sdio_oe_o = 1'b0, // Master drives data
    output reg [7:0] rd_o = 8'h00, // Byte read
    output reg rd_done_o = 1'b0 // Read ended
);
    task automatic w(input integer n);
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic xfer(input [15:0] ins, input [23:0] wd, input lsb,
        input stall);
        integer j, k, p;
        reg [7:0] rd;
        rd = 8'h00;
        cs_n_o <= 1'b0;
        w(8);
        for (j = 0; j < 16 + 8 * (ins[14:13] + 1); j = j + 1)
        begin
            k = (j - 16) / 8;
            p = lsb ? (j - 16) % 8 : 7 - (j - 16) % 8;
            if (stall && j > 16 && j % 8 == 0)
            begin
                cs_n_o <= 1'b1;
                w(16);
                cs_n_o <= 1'b0;
                w(8);
            end
            sclk_o <= 1'b0;
            sdio_oe_o <= !(ins[15] && j >= 16);
            sdio_o <= j < 16 ? ins[lsb ? (j == 0 ? 15 : j < 3 ? 12 + j :
                j - 3) : 15 - j] : wd[8 * k + p];
            w(8);
            sclk_o <= 1'b1;
            if (j >= 16)
                rd[p] = sdio_i;
            w(8);
        end
        cs_n_o <= 1'b1;
        sdio_oe_o <= 1'b0;
        w(1);
        sclk_o <= 1'b0;
        rd_o <= rd;
        rd_done_o <= ins[15];
        w(1);
        rd_done_o <= 1'b0;
        w(40);
    endtask
endmodule // spi_master_model

// File: tb/converter_config_serial_port_tb.sv
// Self-checking bench for the configuration serial port
`timescale 1ns/1ps
`include "cfg_port_map.vh"
module converter_config_serial_port_tb;
    reg clk_sys_i = 1'b0;
    reg rst_i = 1'b1;
    reg pat = 1'b0;
    reg lsb = 1'b0;
    reg [31:0] seed = 32'h34B19864;
    reg [7:0] va, vb, pm;
    reg [7:0] exp_q[$];
    integer error_cnt = 0;
    integer n_compared = 0;
    wire sclk, cs_n, m_d, m_oe, d_o, d_oe, act, stab, done, sdio;
    wire [1:0] pwr;
    wire [7:0] cha, chb, rd;
    assign sdio = d_oe ? d_o : m_oe ? m_d : pat;
    always #5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i)
        pat <= ~pat;
    cfg_serial_port i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .sclk_i(sclk), .cs_n_i(cs_n), .sdio_i(sdio), .sdio_o(d_o),
        .sdio_oe_o(d_oe), .power_mode_o(pwr),
        .duty_cycle_stabilizer_o(stab), .chan_a_cfg_o(cha),
        .chan_b_cfg_o(chb), .port_active_o(act));
    spi_master_model i_master (.clk_sys_i(clk_sys_i), .sdio_i(sdio),
        .sclk_o(sclk), .cs_n_o(cs_n), .sdio_o(m_d), .sdio_oe_o(m_oe),
        .rd_o(rd), .rd_done_o(done));
    function automatic [7:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        rnd = seed[7:0];
    endfunction
    task cmp(input [7:0] got, input [7:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task give_verdict;
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task wr(input [12:0] a, input [7:0] d);
        i_master.xfer({1'b0, 2'b00, a}, {16'h0000, d}, lsb, 1'b0);
    endtask
    task rdq(input [12:0] a, input [7:0] e);
        exp_q.push_back(e);
        i_master.xfer({1'b1, 2'b00, a}, 24'h000000, lsb, 1'b0);
    endtask
    // Select channels, then touch the first local byte
    task cw(input [7:0] s, input [7:0] d);
        wr(`ADDR_CHAN_INDEX, s);
        wr(13'h0010, d);
    endtask
    task cr(input [7:0] s, input [7:0] e);
        wr(`ADDR_CHAN_INDEX, s);
        rdq(13'h0010, e);
    endtask
    always @(posedge clk_sys_i)
        if (done === 1'b1)
            cmp(rd, exp_q.pop_front());
    initial
    begin
        repeat (40000) @(posedge clk_sys_i);
        error_cnt = error_cnt + 1;
        give_verdict;
    end
    initial
    begin
        repeat (4) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_sys_i);
        cmp({7'h00, d_oe}, 8'h00);
        cmp({6'h00, pwr}, 8'h00);
        cmp({7'h00, stab}, 8'h01);
        cmp(cha | chb, 8'h00);
        pm = rnd() & 8'h03;
        wr(`ADDR_POWER_MODE, pm);
        cmp({6'h00, pwr}, pm);
        rdq(`ADDR_POWER_MODE, pm);
        wr(`ADDR_CLOCK_CFG, 8'h00);
        cmp({7'h00, stab}, 8'h01);
        va = rnd() & 8'h03;
        i_master.xfer({1'b0, 2'b01, `ADDR_CLOCK_CFG}, {8'h00, va, 8'h00},
            lsb, 1'b1);
        cmp({6'h00, pwr}, va);
        wr(`ADDR_TRANSFER, `TRANSFER_GO);
        cmp({7'h00, stab}, 8'h00);
        rdq(`ADDR_TRANSFER, 8'h00);
        va = rnd();
        vb = rnd();
        cw(8'h01, va);
        cw(8'h02, vb);
        cr(8'h03, va);
        cr(8'h02, vb);
        cw(8'h03, pm ^ 8'h5A);
        cr(8'h02, pm ^ 8'h5A);
        wr(`ADDR_PORT_CFG, 8'h01 << `PORT_CFG_LSB_BIT);
        lsb = 1'b1;
        pm = rnd() & 8'h03;
        wr(`ADDR_POWER_MODE, pm);
        rdq(`ADDR_POWER_MODE, pm);
        cmp(exp_q.size(), 8'h00);
        give_verdict;
    end
endmodule // converter_config_serial_port_tb
